// ==== logic/pmofs_pkg.sv ====
// Purpose: Shared constants for the overflow status and freeze block
// Assumes: Four 64-bit status words, freeze in bit 0 of word 0
// Notes: Counter and monitor counts are module parameters
//
// Summary of operation
// - Four 64-bit status words hold 252 overflow indication bits.
// - Counter pair i reports in word i/64, bit i%64, from i=4.
// - Overflow with irq enable, or monitor request: set bit, interrupt, freeze.
// - Overflow without irq enable sets its bit only; counting goes on.
// - Vector mask one blocks pending the interrupt; zero holds it pending.
// - Freeze flag sits at bit 0 of word 0.
// - Bits 3:0 of word 0 never carry overflows; bits 3:1 ignored.
// - While frozen, counters hold and overflow bits and monitors freeze.
// - Software writing zero to the freeze flag resumes counting.
// - Software may write one to the freeze flag to stop counting.
// - Overflow bits are sticky and set on every overflow.
// - Concurrent overflows set every matching bit.
// - Hardware only sets overflow and freeze bits, never clears them.
// - Bits of unimplemented counters read zero and ignore writes.
// - An event counts retired instructions, nops and predicated-off ones.
// - An event counts cycles in normal or low-power state.
// - Each event may be countable only on a reported counter subset.
// - A counter overflows on carry out of its top bit.
// - A counter runs only unfrozen, privilege admitted and monitor enabled.
package pmofs_pkg;
    localparam int unsigned NUM_WORDS = 4;
    localparam int unsigned WORD_W = 64;
    localparam int unsigned ALL_W = NUM_WORDS * WORD_W;
    localparam int unsigned WORD_SH = 6;
    localparam int unsigned STAT_IDX_W = 2;
    localparam int unsigned OVF_BITS = 252;
    localparam int unsigned FREEZE_BIT = 0;
    localparam int unsigned IGN_LSB = 1;
    localparam int unsigned IGN_MSB = 3;
    localparam int unsigned FIRST_GENERIC = 4;
    localparam int unsigned PLM_W = 4;
    localparam int unsigned CPL_W = 2;
    localparam int unsigned SEL_W = 2;
    localparam logic [ALL_W-1:0] STAT_RESET = '0;
    localparam logic [ALL_W-1:0] WORD_ONES =
        {{(ALL_W - WORD_W){1'b0}}, {WORD_W{1'b1}}};
    localparam logic [WORD_W-1:0] RDATA_RESET = '0;
    localparam logic PENDING_RESET = 1'b0;

    // Event select codes, Gray ordered
    typedef enum logic [SEL_W-1:0] {
        EVT_RETIRED = 2'h0,
        EVT_CYCLES = 2'h1,
        EVT_EXT = 2'h3,
        EVT_NONE = 2'h2
    } pmofs_evt_t;
endpackage : pmofs_pkg

// ==== logic/pmofs_cnt_if.sv ====
// Purpose: Carrier between the status logic and one generic counter
// Assumes: One instance per counter
// Notes: Overflow is a combinational pulse in the counting cycle
`timescale 1ns/10ps
interface pmofs_cnt_if #(
    parameter int unsigned W = 32
);
    logic run;
    logic evt;
    logic wr;
    logic [W-1:0] wdata;
    logic [W-1:0] value;
    logic ovf;
    modport ctl (output run, output evt, output wr, output wdata,
                 input value, input ovf);
    modport cnt (input run, input evt, input wr, input wdata,
                 output value, output ovf);
endinterface : pmofs_cnt_if

// ==== logic/pmofs_counter.sv ====
// Purpose: One generic event counter with carry-out overflow detect
// Assumes: Control side supplies run, selected event and load
// Notes: A software load in the same cycle as a count wins
`timescale 1ns/10ps
module pmofs_counter #(
    parameter int unsigned W = 32
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Control side
    pmofs_cnt_if.cnt bus
);
    logic [W-1:0] count;
    logic [W:0] sum;
    logic bump;

    assign bump = bus.run & bus.evt;
    assign sum = {1'b0, count} + {{W{1'b0}}, 1'b1};
    assign bus.ovf = bump & sum[W] & ~bus.wr;
    assign bus.value = count;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count <= '0;
        end else if (bus.wr) begin
            count <= bus.wdata;
        end else if (bump) begin
            count <= sum[W-1:0];
        end
    end

    property wrap_p;
        @(posedge i_clk) disable iff (!i_rst_n)
        (bump && !bus.wr && count == '1) |-> bus.ovf ##1 count == '0;
    endproperty
    counter_wrap_a: assert property (wrap_p)
        else $error("counter wrap not flagged as overflow");

    property no_false_ovf_p;
        @(posedge i_clk) disable iff (!i_rst_n)
        bus.ovf |-> (bump && count == '1);
    endproperty
    ovf_cause_a: assert property (no_false_ovf_p)
        else $error("overflow without carry out");
endmodule : pmofs_counter

// ==== logic/pmofs_top.sv ====
// Purpose: Overflow status words, freeze control and overflow interrupt
// Assumes: Register strobes come from the move-to/from config path
// Notes: Read data appears one cycle after the read strobe
`timescale 1ns/10ps
module pmofs_top #(
    parameter int unsigned NUM_CNT = 4,
    parameter int unsigned CNT_W = 32,
    parameter int unsigned NUM_MSM = 4,
    parameter int unsigned MSM_BASE = 128,
    parameter logic [NUM_CNT-1:0] RETIRED_SUPPORT = '1,
    parameter logic [NUM_CNT-1:0] CYCLES_SUPPORT = '1,
    parameter logic [NUM_CNT-1:0] EXT_SUPPORT = '1,
    localparam int unsigned CIDX_W = (NUM_CNT > 1) ? $clog2(NUM_CNT) : 1
) (
    // Clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    // Status word access
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    input wire logic [pmofs_pkg::STAT_IDX_W-1:0] I_REG_IDX,
    input wire logic [pmofs_pkg::WORD_W-1:0] I_REG_WDATA,
    output logic [pmofs_pkg::WORD_W-1:0] O_REG_RDATA,
    // Counter data access
    input wire logic I_CNT_WR,
    input wire logic [CIDX_W-1:0] I_CNT_IDX,
    input wire logic [CNT_W-1:0] I_CNT_WDATA,
    output logic [NUM_CNT*CNT_W-1:0] O_CNT_VALUE,
    // Counter configuration
    input wire logic [NUM_CNT-1:0] I_OVERFLOW_IRQ_ENABLE,
    input wire logic [NUM_CNT-1:0] I_PRIVILEGED_MONITOR_SELECT,
    input wire logic [NUM_CNT*pmofs_pkg::PLM_W-1:0] I_CNT_PLM,
    input wire logic [NUM_CNT*pmofs_pkg::SEL_W-1:0] I_CNT_SEL,
    // Processor status
    input wire logic I_USER_MONITOR_ENABLE,
    input wire logic I_PRIVILEGED_MONITOR_ENABLE,
    input wire logic [pmofs_pkg::CPL_W-1:0] I_CPL,
    input wire logic I_OVERFLOW_VECTOR_MASK,
    // Events
    input wire logic I_INSN_RETIRED,
    input wire logic I_CYCLE_COUNTABLE,
    input wire logic I_EXT_EVENT,
    // Model-specific monitors
    input wire logic [NUM_MSM-1:0] I_MSM_IRQ_REQ,
    output logic O_MONITOR_FROZEN,
    // Interrupt path
    input wire logic I_PMI_ACK,
    output logic O_PMI_RAISE,
    output logic O_PMI_PENDING,
    // Event capability query
    output logic [3*NUM_CNT-1:0] O_EVENT_SUPPORT
);
    localparam int unsigned ALL_W = pmofs_pkg::ALL_W;
    localparam int unsigned WORD_W = pmofs_pkg::WORD_W;
    localparam int unsigned FIRST = pmofs_pkg::FIRST_GENERIC;
    localparam int unsigned PLM_W = pmofs_pkg::PLM_W;
    localparam int unsigned SEL_W = pmofs_pkg::SEL_W;

    // Bits that exist: freeze flag, counters, model-specific monitors
    function automatic logic [ALL_W-1:0] impl_mask();
        logic [ALL_W-1:0] m;
        m = '0;
        m[pmofs_pkg::FREEZE_BIT] = 1'b1;
        for (int i = 0; i < NUM_CNT; i++) begin
            m[FIRST + i] = 1'b1;
        end
        for (int i = 0; i < NUM_MSM; i++) begin
            m[MSM_BASE + i] = 1'b1;
        end
        return m;
    endfunction : impl_mask

    localparam logic [ALL_W-1:0] impl_bits = impl_mask();

    // Privilege mask and user or privileged monitor enable
    function automatic logic mon_enable(
        input logic [PLM_W-1:0] plm,
        input logic [pmofs_pkg::CPL_W-1:0] cpl,
        input logic psel,
        input logic uen,
        input logic pen
    );
        return plm[cpl] & (psel ? pen : uen);
    endfunction : mon_enable

    // Selected event, gated by the counter's support bits
    function automatic logic evt_pick(
        input pmofs_pkg::pmofs_evt_t sel,
        input logic retired,
        input logic cycles,
        input logic ext
    );
        logic e;
        e = 1'b0;
        unique case (sel)
            pmofs_pkg::EVT_RETIRED: e = retired;
            pmofs_pkg::EVT_CYCLES: e = cycles;
            pmofs_pkg::EVT_EXT: e = ext;
            pmofs_pkg::EVT_NONE: e = 1'b0;
        endcase
        return e;
    endfunction : evt_pick

    logic [ALL_W-1:0] stat;
    logic [ALL_W-1:0] next_stat;
    logic [ALL_W-1:0] set_vec;
    logic [ALL_W-1:0] wr_sel;
    logic [ALL_W-1:0] wr_data;
    logic [pmofs_pkg::STAT_IDX_W+pmofs_pkg::WORD_SH-1:0] word_base;
    logic [WORD_W-1:0] rd_word;
    logic freeze_flag;
    logic freeze_set;
    logic [NUM_CNT-1:0] run;
    logic [NUM_CNT-1:0] cnt_evt;
    logic [NUM_CNT-1:0] ovf;
    logic [NUM_CNT-1:0] irq_ovf;
    logic [NUM_MSM-1:0] msm_req;
    logic pending;
    logic next_pending;
    logic pmi_raise;

    assign freeze_flag = stat[pmofs_pkg::FREEZE_BIT];
    assign O_MONITOR_FROZEN = freeze_flag;
    assign O_EVENT_SUPPORT = {EXT_SUPPORT, CYCLES_SUPPORT,
                              RETIRED_SUPPORT};

    // Counters
    for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
        pmofs_cnt_if #(.W(CNT_W)) cif ();
        pmofs_counter #(.W(CNT_W)) u_cnt (
            .i_clk(I_CLK_SYS),
            .i_rst_n(I_RST_N),
            .bus(cif.cnt)
        );
        assign run[g] = ~freeze_flag & mon_enable(
            I_CNT_PLM[g*PLM_W +: PLM_W], I_CPL,
            I_PRIVILEGED_MONITOR_SELECT[g],
            I_USER_MONITOR_ENABLE,
            I_PRIVILEGED_MONITOR_ENABLE);
        assign cnt_evt[g] = evt_pick(
            pmofs_pkg::pmofs_evt_t'(I_CNT_SEL[g*SEL_W +: SEL_W]),
            I_INSN_RETIRED & RETIRED_SUPPORT[g],
            I_CYCLE_COUNTABLE & CYCLES_SUPPORT[g],
            I_EXT_EVENT & EXT_SUPPORT[g]);
        assign cif.run = run[g];
        assign cif.evt = cnt_evt[g];
        assign cif.wr = I_CNT_WR & (I_CNT_IDX == CIDX_W'(g));
        assign cif.wdata = I_CNT_WDATA;
        assign ovf[g] = cif.ovf;
        assign O_CNT_VALUE[g*CNT_W +: CNT_W] = cif.value;
    end

    // Interrupting events
    assign irq_ovf = ovf & I_OVERFLOW_IRQ_ENABLE;
    assign msm_req = I_MSM_IRQ_REQ & {NUM_MSM{~freeze_flag}};
    assign freeze_set = (|irq_ovf) | (|msm_req);

    // Hardware set vector: every overflow, plus freeze on interrupt
    always_comb begin
        set_vec = '0;
        for (int i = 0; i < NUM_CNT; i++) begin
            set_vec[FIRST + i] = ovf[i];
        end
        for (int i = 0; i < NUM_MSM; i++) begin
            set_vec[MSM_BASE + i] = msm_req[i];
        end
        set_vec[pmofs_pkg::FREEZE_BIT] = freeze_set;
    end

    // Software write window onto one word
    assign word_base = {I_REG_IDX, {pmofs_pkg::WORD_SH{1'b0}}};
    assign wr_sel = I_REG_WR ? (pmofs_pkg::WORD_ONES << word_base) : '0;
    assign wr_data = {pmofs_pkg::NUM_WORDS{I_REG_WDATA}};
    // Unimplemented and ignored bits never store; sets win over the write
    assign next_stat = (((stat & ~wr_sel) | (wr_data & wr_sel))
                        & impl_bits) | set_vec;
    assign rd_word = stat[word_base +: WORD_W];

    // Interrupt pending: mask blocks pending, a new request wins over ack
    assign next_pending = (freeze_set & ~I_OVERFLOW_VECTOR_MASK)
                          | (pending & ~I_PMI_ACK);

    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            stat <= pmofs_pkg::STAT_RESET;
        end else begin
            stat <= next_stat;
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            pending <= pmofs_pkg::PENDING_RESET;
            pmi_raise <= 1'b0;
        end else begin
            pending <= next_pending;
            pmi_raise <= freeze_set;
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_REG_RDATA <= pmofs_pkg::RDATA_RESET;
        end else if (I_REG_RD) begin
            O_REG_RDATA <= rd_word;
        end
    end

    assign O_PMI_RAISE = pmi_raise;
    assign O_PMI_PENDING = pending;

    // Checks
    sequence s_irq_evt;
        freeze_set;
    endsequence

    sequence s_frozen_raised;
        freeze_flag && O_PMI_RAISE;
    endsequence

    property irq_freeze_p;
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        s_irq_evt |=> s_frozen_raised;
    endproperty
    irq_freezes_a: assert property (irq_freeze_p)
        else $error("interrupting overflow did not freeze and raise");

    property quiet_wrap_p;
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (ovf != '0 && !freeze_set && !freeze_flag && !I_REG_WR)
        |=> !freeze_flag && !O_PMI_RAISE;
    endproperty
    quiet_wrap_a: assert property (quiet_wrap_p)
        else $error("overflow without irq enable froze counting");

    property ovf_record_p;
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        ovf != '0 |=>
        (stat[FIRST +: NUM_CNT] & $past(ovf)) == $past(ovf);
    endproperty
    ovf_recorded_a: assert property (ovf_record_p)
        else $error("overflow not recorded in its status bit");

    property pend_p;
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (freeze_set && !I_OVERFLOW_VECTOR_MASK) |=> pending;
    endproperty
    pend_taken_a: assert property (pend_p)
        else $error("unmasked interrupt not pending");

    property mask_p;
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (I_OVERFLOW_VECTOR_MASK && !pending) |=> !pending;
    endproperty
    mask_blocks_a: assert property (mask_p)
        else $error("masked interrupt became pending");

    property frozen_hold_p;
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (freeze_flag && !I_CNT_WR) |=> $stable(O_CNT_VALUE);
    endproperty
    frozen_hold_a: assert property (frozen_hold_p)
        else $error("counter moved while frozen");

    property frozen_quiet_p;
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (freeze_flag && !I_REG_WR) |=> $stable(stat);
    endproperty
    frozen_status_a: assert property (frozen_quiet_p)
        else $error("status changed while frozen");

    property unfreeze_p;
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (I_REG_WR && I_REG_IDX == '0 && !I_REG_WDATA[0] && !freeze_set)
        |=> !freeze_flag;
    endproperty
    unfreeze_write_a: assert property (unfreeze_p)
        else $error("zero write did not clear freeze");

    property freeze_wr_p;
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (I_REG_WR && I_REG_IDX == '0 && I_REG_WDATA[0])
        |=> freeze_flag && (run == '0);
    endproperty
    freeze_write_a: assert property (freeze_wr_p)
        else $error("software freeze did not stop counting");

    property sticky_p;
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        !I_REG_WR |=> (stat & $past(stat)) == $past(stat);
    endproperty
    bits_sticky_a: assert property (sticky_p)
        else $error("status bit cleared by hardware");

    property set_wins_p;
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (I_REG_WR && I_REG_IDX == '0 && !I_REG_WDATA[0] && freeze_set)
        |=> freeze_flag;
    endproperty
    set_wins_a: assert property (set_wins_p)
        else $error("software clear beat hardware set");

    property unimpl_p;
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        I_REG_RD |=> ((O_REG_RDATA &
            ~$past(impl_bits[word_base +: WORD_W])) == '0);
    endproperty
    unimpl_zero_a: assert property (unimpl_p)
        else $error("unimplemented or ignored bit read as one");

    property ign_bits_p;
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        stat[pmofs_pkg::IGN_MSB:pmofs_pkg::IGN_LSB] == '0;
    endproperty
    ign_bits_zero_a: assert property (ign_bits_p)
        else $error("ignored bits of word 0 hold a one");

    property unimpl_stat_p;
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (stat & ~impl_bits) == '0;
    endproperty
    unimpl_store_a: assert property (unimpl_stat_p)
        else $error("unimplemented status bit stored a one");

    property raise_pulse_p;
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        O_PMI_RAISE |=> !O_PMI_RAISE;
    endproperty
    raise_pulse_a: assert property (raise_pulse_p)
        else $error("interrupt raise longer than one cycle");

    property ack_clear_p;
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (I_PMI_ACK && !freeze_set) |=> !pending;
    endproperty
    ack_clears_a: assert property (ack_clear_p)
        else $error("acknowledge did not clear pending");
endmodule : pmofs_top

// ==== testbench/pmofs_irq_model.sv ====
// Purpose: Interrupt delivery side that accepts a pending overflow irq
// Assumes: Acknowledge is a one-cycle pulse, driven at the falling edge
// Notes: Delay sets how many cycles the pending level waits before ack
`timescale 1ns/10ps
module pmofs_irq_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Control from the bench
    input wire logic i_en,
    input wire logic [3:0] i_delay,
    // Interrupt path
    input wire logic i_pending,
    output logic o_ack
);
    logic [3:0] wait_cnt;

    // Ack only after the pending level has been seen for delay cycles
    always @(negedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wait_cnt <= 4'h0;
            o_ack <= 1'h0;
        end else if (i_en && i_pending && !o_ack) begin
            o_ack <= (wait_cnt == i_delay);
            wait_cnt <= (wait_cnt == i_delay) ? 4'h0 : wait_cnt + 4'h1;
        end else begin
            o_ack <= 1'h0;
            wait_cnt <= 4'h0;
        end
    end
endmodule : pmofs_irq_model

// ==== testbench/tb.sv ====
// Purpose: Self-checking bench for the overflow status and freeze block
// Assumes: Default parameters, counter k reports at status bit 4+k
// Notes: Inputs change at the falling edge, outputs read there too
`timescale 1ns/10ps
module tb;
    logic clk, rst_n, reg_wr, reg_rd, cnt_wr, uen, pen, vmask;
    logic ret, cyc, ext, ack, irq_en, frozen, raise, pend;
    logic [1:0] reg_idx, cnt_idx, cpl;
    logic [63:0] wdata, rdata, d;
    logic [31:0] cwdata;
    logic [127:0] cval;
    logic [3:0] oie, psel, msm;
    logic [15:0] plm;
    logic [7:0] sel;
    logic [11:0] sup;
    int fails, cmp_count;

    pmofs_top dut_u (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_REG_WR(reg_wr),
        .I_REG_RD(reg_rd), .I_REG_IDX(reg_idx), .I_REG_WDATA(wdata),
        .O_REG_RDATA(rdata), .I_CNT_WR(cnt_wr), .I_CNT_IDX(cnt_idx),
        .I_CNT_WDATA(cwdata), .O_CNT_VALUE(cval),
        .I_OVERFLOW_IRQ_ENABLE(oie), .I_PRIVILEGED_MONITOR_SELECT(psel),
        .I_CNT_PLM(plm), .I_CNT_SEL(sel), .I_USER_MONITOR_ENABLE(uen),
        .I_PRIVILEGED_MONITOR_ENABLE(pen), .I_CPL(cpl),
        .I_OVERFLOW_VECTOR_MASK(vmask), .I_INSN_RETIRED(ret),
        .I_CYCLE_COUNTABLE(cyc), .I_EXT_EVENT(ext), .I_MSM_IRQ_REQ(msm),
        .O_MONITOR_FROZEN(frozen), .I_PMI_ACK(ack), .O_PMI_RAISE(raise),
        .O_PMI_PENDING(pend), .O_EVENT_SUPPORT(sup));

    pmofs_irq_model irq_u (.i_clk(clk), .i_rst_n(rst_n), .i_en(irq_en),
        .i_delay(4'h3), .i_pending(pend), .o_ack(ack));

    task automatic end_sim;
        if (fails == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string n, input logic [63:0] e, g);
        cmp_count++;
        if (g !== e) begin
            $display("MISMATCH %s exp %h got %h", n, e, g);
            fails++;
        end
    endtask : chk

    task automatic wr(input logic [1:0] i, input logic [63:0] v);
        @(negedge clk);
        reg_wr = 1'h1;
        reg_idx = i;
        wdata = v;
        @(negedge clk);
        reg_wr = 1'h0;
    endtask : wr

    task automatic rd(input logic [1:0] i, output logic [63:0] v);
        @(negedge clk);
        reg_rd = 1'h1;
        reg_idx = i;
        @(negedge clk);
        reg_rd = 1'h0;
        v = rdata;
    endtask : rd

    task automatic ld(input logic [1:0] k, input logic [31:0] v);
        @(negedge clk);
        cnt_wr = 1'h1;
        cnt_idx = k;
        cwdata = v;
        @(negedge clk);
        cnt_wr = 1'h0;
    endtask : ld

    task automatic pulse_ext(input int n);
        @(negedge clk);
        ext = 1'h1;
        repeat (n) @(negedge clk);
        ext = 1'h0;
    endtask : pulse_ext

    task automatic clr_all;
        for (int w = 3; w >= 0; w--) begin
            wr(w[1:0], 64'h0);
        end
    endtask : clr_all

    task automatic t_reset;
        for (int w = 0; w < 4; w++) begin
            rd(w[1:0], d);
            chk("reset word", 64'h0, d);
        end
        chk("frozen", 64'h0, {63'h0, frozen});
        chk("support", 64'hFFF, {52'h0, sup});
    endtask : t_reset

    task automatic t_regs;
        for (int w = 0; w < 4; w++) begin
            wr(w[1:0], 64'hFFFFFFFFFFFFFFFF);
        end
        rd(2'h0, d);
        chk("word0 ones", 64'hF1, d);
        chk("frozen sw", 64'h1, {63'h0, frozen});
        rd(2'h1, d);
        chk("word1 ones", 64'h0, d);
        rd(2'h2, d);
        chk("word2 ones", 64'hF, d);
        rd(2'h3, d);
        chk("word3 ones", 64'h0, d);
        clr_all();
        rd(2'h0, d);
        chk("word0 clear", 64'h0, d);
        chk("frozen clr", 64'h0, {63'h0, frozen});
    endtask : t_regs

    task automatic t_events;
        sel = {pmofs_pkg::EVT_NONE, pmofs_pkg::EVT_RETIRED,
               pmofs_pkg::EVT_CYCLES, pmofs_pkg::EVT_RETIRED};
        ld(2'h0, 32'h0);
        ld(2'h1, 32'h0);
        ld(2'h2, 32'h0);
        plm[0] = 1'h0;
        psel[2] = 1'h1;
        pen = 1'h0;
        uen = 1'h0;
        @(negedge clk);
        ret = 1'h1;
        cyc = 1'h1;
        repeat (3) @(negedge clk);
        ret = 1'h0;
        cyc = 1'h0;
        chk("cnt0 plm off", 64'h0, {32'h0, cval[31:0]});
        chk("cnt1 uen off", 64'h0, {32'h0, cval[63:32]});
        chk("cnt2 pen off", 64'h0, {32'h0, cval[95:64]});
        cpl = 2'h1;
        pen = 1'h1;
        uen = 1'h1;
        @(negedge clk);
        ret = 1'h1;
        cyc = 1'h1;
        repeat (3) @(negedge clk);
        ret = 1'h0;
        repeat (2) @(negedge clk);
        cyc = 1'h0;
        chk("cnt0 retired", 64'h3, {32'h0, cval[31:0]});
        chk("cnt1 cycles", 64'h5, {32'h0, cval[63:32]});
        chk("cnt2 priv", 64'h3, {32'h0, cval[95:64]});
        chk("cnt3 none", 64'h0, {32'h0, cval[127:96]});
        cpl = 2'h0;
        plm = 16'hFFFF;
        psel = 4'h0;
        sel = {4{pmofs_pkg::EVT_EXT}};
    endtask : t_events

    task automatic t_wrap;
        ld(2'h0, 32'hFFFFFFFF);
        pulse_ext(1);
        chk("wrap value", 64'h0, {32'h0, cval[31:0]});
        chk("no freeze", 64'h0, {63'h0, frozen});
        chk("no raise", 64'h0, {63'h0, raise});
        pulse_ext(1);
        chk("keeps count", 64'h1, {32'h0, cval[31:0]});
        rd(2'h0, d);
        chk("sticky bit4", 64'h10, d);
    endtask : t_wrap

    task automatic t_irq;
        int n;
        oie = 4'h6;
        ld(2'h1, 32'hFFFFFFFF);
        ld(2'h2, 32'hFFFFFFFF);
        pulse_ext(1);
        chk("raise", 64'h1, {63'h0, raise});
        chk("frozen hw", 64'h1, {63'h0, frozen});
        chk("pending", 64'h1, {63'h0, pend});
        @(negedge clk);
        chk("raise pulse", 64'h0, {63'h0, raise});
        msm = 4'h1;
        pulse_ext(3);
        msm = 4'h0;
        chk("frozen cnt", 64'h0000000300000000, cval[127:64]);
        rd(2'h0, d);
        chk("word0 both", 64'h61, d);
        rd(2'h2, d);
        chk("msm frozen", 64'h0, d);
        irq_en = 1'h1;
        n = 0;
        while (pend === 1'h1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        irq_en = 1'h0;
        chk("ack clears", 64'h0, {63'h0, pend});
        if (n >= 20) begin
            end_sim();
        end
        chk("still frozen", 64'h1, {63'h0, frozen});
        wr(2'h0, 64'h0);
        pulse_ext(1);
        chk("resumed", 64'h1, {32'h0, cval[63:32]});
        oie = 4'h0;
    endtask : t_irq

    task automatic t_mask;
        vmask = 1'h1;
        @(negedge clk);
        msm = 4'h2;
        @(negedge clk);
        msm = 4'h0;
        chk("msm raise", 64'h1, {63'h0, raise});
        chk("msm freeze", 64'h1, {63'h0, frozen});
        chk("masked", 64'h0, {63'h0, pend});
        rd(2'h2, d);
        chk("msm bit", 64'h2, d);
        clr_all();
        vmask = 1'h0;
    endtask : t_mask

    task automatic t_race;
        oie = 4'h1;
        ld(2'h0, 32'hFFFFFFFF);
        @(negedge clk);
        ext = 1'h1;
        reg_wr = 1'h1;
        reg_idx = 2'h0;
        wdata = 64'h0;
        @(negedge clk);
        ext = 1'h0;
        reg_wr = 1'h0;
        rd(2'h0, d);
        chk("set wins", 64'h11, d);
        chk("race frozen", 64'h1, {63'h0, frozen});
    endtask : t_race

    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    initial begin
        fails = 0;
        cmp_count = 0;
        {rst_n, reg_wr, reg_rd, cnt_wr, vmask, ret, cyc, ext} = 8'h0;
        {uen, pen, irq_en} = 3'h6;
        {reg_idx, cnt_idx, cpl} = 6'h0;
        wdata = 64'h0;
        cwdata = 32'h0;
        {oie, psel, msm} = 12'h0;
        plm = 16'hFFFF;
        sel = 8'hAA;
        repeat (16) @(negedge clk);
        rst_n = 1'h1;
        t_reset();
        t_regs();
        t_events();
        t_wrap();
        clr_all();
        t_irq();
        clr_all();
        t_mask();
        t_race();
        end_sim();
    end
endmodule : tb
